// ==== logic/afe_pkg.sv ====
package afe_pkg;

  // Register indices
  localparam logic [4:0] REG_PORT_CFG  = 5'h00;
  localparam logic [4:0] REG_PWR_DOWN  = 5'h01;
  localparam logic [4:0] REG_SPARE     = 5'h02;
  localparam logic [4:0] REG_CLK_SRC   = 5'h03;
  localparam logic [4:0] REG_RX_FILT   = 5'h04;
  localparam logic [4:0] REG_TUNE      = 5'h05;
  localparam logic [4:0] REG_RX_GAIN   = 5'h06;
  localparam logic [4:0] REG_TX_PATH   = 5'h07;
  localparam logic [4:0] REG_RX_CLKOUT = 5'h08;
  localparam logic [4:0] REG_DIE_VER   = 5'h0f;

  // Reset values
  localparam logic [7:0] RST_PORT_CFG  = 8'h00;
  localparam logic [7:0] RST_PWR_DOWN  = 8'h00;
  localparam logic [7:0] RST_SPARE     = 8'h00;
  localparam logic [7:0] RST_CLK_SRC   = 8'h01;
  localparam logic [7:0] RST_RX_FILT   = 8'h01;
  localparam logic [7:0] RST_TUNE      = 8'h80;
  localparam logic [7:0] RST_RX_GAIN   = 8'h00;
  localparam logic [7:0] RST_TX_PATH   = 8'h10;
  localparam logic [7:0] RST_RX_CLKOUT = 8'h00;

  // Writable bit masks
  localparam logic [7:0] MASK_PORT_CFG = 8'he0;
  localparam logic [7:0] MASK_PWR_DOWN = 8'h3f;
  localparam logic [7:0] MASK_CLK_SRC  = 8'h43;
  localparam logic [7:0] MASK_RX_FILT  = 8'hbf;
  localparam logic [7:0] MASK_RX_GAIN  = 8'hbf;
  localparam logic [7:0] MASK_TX_PATH  = 8'hf3;
  localparam logic [7:0] MASK_RX_CLKOUT = 8'hfb;
  localparam logic [7:0] MASK_ALL      = 8'hff;
  localparam logic [7:0] MASK_NONE     = 8'h00;

  // Field positions
  localparam int unsigned BIT_FOUR_WIRE = 7;
  localparam int unsigned BIT_LSB_FIRST = 6;
  localparam int unsigned BIT_SOFT_RST  = 5;
  localparam int unsigned BIT_PD_FILT   = 0;
  localparam int unsigned BIT_PD_ADC    = 1;
  localparam int unsigned BIT_PD_REF    = 2;
  localparam int unsigned BIT_PD_INTERP = 3;
  localparam int unsigned BIT_PD_DAC    = 4;
  localparam int unsigned BIT_PD_PLL    = 5;
  localparam int unsigned BIT_ADC_DIV2  = 6;
  localparam int unsigned BIT_LPF_BYP   = 0;
  localparam int unsigned BIT_ONE_POLE  = 1;
  localparam int unsigned BIT_WIDE_LPF  = 2;
  localparam int unsigned BIT_TUNE_BUSY = 6;
  localparam int unsigned BIT_READ      = 7;

  // Soft reset duration in clock cycles
  localparam logic [3:0] SOFT_RST_CYCLES = 4'h8;
  localparam logic [2:0] BIT_LAST        = 3'h7;

  // Instruction fields
  typedef struct packed {
    logic       rd;
    logic [1:0] count;
    logic [4:0] addr;
  } afe_instr_t;

  // Controls driven toward the analog blocks
  typedef struct packed {
    logic       pd_rx_filter;
    logic       bypass_rx_filter;
    logic       pd_adc_sgain;
    logic       pd_adc_ref;
    logic       pd_interp;
    logic       pd_dac;
    logic       pd_tx_pll;
    logic       clk_a_hiz;
    logic [3:0] pll_factor;
    logic       adc_clk_div2;
    logic       one_pole_en;
    logic [7:0] tune_target;
    logic       wide_cutoff;
  } afe_ctrl_t;

endpackage

// ==== logic/afe_sync.sv ====
`timescale 1ns/1ns
// Two-stage synchroniser for pin inputs
module afe_sync #(
  parameter int unsigned WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // Refuse an empty synchroniser
  if (WIDTH == 0) begin : g_width_check
    $error("sync width must be at least one");
  end

  // First stage is read only by the second
  always_ff @(posedge clock) begin
    if (!nrst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // afe_sync

// ==== logic/afe_regfile.sv ====
`timescale 1ns/1ns
// Register storage with hardware and soft reset
module afe_regfile #(
  parameter logic [7:0] DIE_VERSION = 8'h05  // Arbitrary value
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       soft_rst,
  // Write and read port
  input  wire logic       wr_en,
  input  wire logic [4:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [4:0] rd_addr,
  output logic      [7:0] rd_data,
  // Register contents
  output logic      [7:0] r0,
  output logic      [7:0] r1,
  output logic      [7:0] r3,
  output logic      [7:0] r4,
  output logic      [7:0] r5
);

  localparam int unsigned NREG = 9;
  logic [7:0] regs_r [NREG];

  function automatic logic [7:0] rst_val(input int unsigned i);
    case (i)
      0:       rst_val = afe_pkg::RST_PORT_CFG;
      1:       rst_val = afe_pkg::RST_PWR_DOWN;
      2:       rst_val = afe_pkg::RST_SPARE;
      3:       rst_val = afe_pkg::RST_CLK_SRC;
      4:       rst_val = afe_pkg::RST_RX_FILT;
      5:       rst_val = afe_pkg::RST_TUNE;
      6:       rst_val = afe_pkg::RST_RX_GAIN;
      7:       rst_val = afe_pkg::RST_TX_PATH;
      default: rst_val = afe_pkg::RST_RX_CLKOUT;
    endcase
  endfunction

  function automatic logic [7:0] wr_mask(input logic [4:0] a);
    case (a)
      afe_pkg::REG_PORT_CFG:  wr_mask = afe_pkg::MASK_PORT_CFG;
      afe_pkg::REG_PWR_DOWN:  wr_mask = afe_pkg::MASK_PWR_DOWN;
      afe_pkg::REG_SPARE:     wr_mask = afe_pkg::MASK_ALL;
      afe_pkg::REG_CLK_SRC:   wr_mask = afe_pkg::MASK_CLK_SRC;
      afe_pkg::REG_RX_FILT:   wr_mask = afe_pkg::MASK_RX_FILT;
      afe_pkg::REG_TUNE:      wr_mask = afe_pkg::MASK_ALL;
      afe_pkg::REG_RX_GAIN:   wr_mask = afe_pkg::MASK_RX_GAIN;
      afe_pkg::REG_TX_PATH:   wr_mask = afe_pkg::MASK_TX_PATH;
      afe_pkg::REG_RX_CLKOUT: wr_mask = afe_pkg::MASK_RX_CLKOUT;
      default:                wr_mask = afe_pkg::MASK_NONE;
    endcase
  endfunction

  // soft reset, masked writes
  // Storage; soft reset spares register 0 except its reset bit
  always_ff @(posedge clock) begin
    for (int unsigned i = 0; i < NREG; i++) begin
      if (!nrst) begin
        regs_r[i] <= rst_val(i);
      end else if (soft_rst) begin
        if (i == 0) begin
          regs_r[i] <= regs_r[i] & ~(8'h01 << afe_pkg::BIT_SOFT_RST);
        end else begin
          regs_r[i] <= rst_val(i);
        end
      end else if (wr_en && wr_addr == 5'(i)) begin
        regs_r[i] <= wr_data & wr_mask(wr_addr);
      end
    end
  end

  // unmapped reads zero
  // Read mux; unmapped addresses read zero
  assign rd_data = (rd_addr == afe_pkg::REG_DIE_VER) ? DIE_VERSION :
                   (rd_addr < 5'(NREG)) ? regs_r[rd_addr[3:0]] : 8'h00;
  assign r0 = regs_r[0];
  assign r1 = regs_r[1];
  assign r3 = regs_r[3];
  assign r4 = regs_r[4];
  assign r5 = regs_r[5];

endmodule // afe_regfile

// ==== logic/afe_ctrl_bank.sv ====
`timescale 1ns/1ns
// Summary of operation
// - Hardware reset disables the serial port and restores every register default.
// - Soft reset restores all but register 0; its reset bit reads zero.
// - Register 0 bit 5 resets the chip, relocks multipliers, then self-clears.
// - Port sequencing counts serial clock edges since select went active.
// - A byte completes every eighth rising edge; multibyte writes update sequentially.
// - Resets leave interpolator contents; host flushes transmit path with zeros.
// - Register 0 bit 6 selects least significant bit first; default MSB first.
// - Register 0 bit 7 selects four-line mode with separate serial output.
// - Four-line output changes on falling serial clock; host samples rising.
// - Register 1 bit 0 powers down and bypasses filter and continuous gain.
// - Register 1 bits 1 and 2 power down ADC/switched gain and reference.
// - Register 1 bit 3 powers down interpolator, bit 4 the DAC.
// - Register 1 bit 5 powers down transmit multiplier; auxiliary clock floats.
// - Register 3 bits 1:0 pick multiplier factor 1, 2, 4 or 8.
// - Register 3 bit 6 clocks the ADC from oscillator input halved.
// - Filter calibrates to low or high cutoff using tuning target register.
// - Register 4 bit 0 bypasses and powers down the four-pole filter.
// - Register 4 bit 1 enables untrimmed single-pole filter when register 4 bit 0 bypasses it.
// - Instruction byte: read flag, byte count minus one, start address.
// - Multibyte addresses decrement MSB-first and increment LSB-first.
// - Input sampled on rising edges; read data updated on falling edges.
// - Select is active low; input ignored while select inactive.
module afe_ctrl_bank #(
  parameter logic [7:0] DIE_VERSION = 8'h05  // Arbitrary value
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              nrst,
  // Serial pins
  input  wire logic              serial_clk,
  input  wire logic              serial_select_n,
  input  wire logic              serial_data_i,
  output logic                   serial_data_o,
  output logic                   serial_data_oe_n,
  output logic                   boost_or_serial_out,
  output logic                   boost_or_serial_oe_n,
  // Analog side
  input  wire logic              rx_boost_level,
  output afe_pkg::afe_ctrl_t     ctrl,
  output logic                   pll_relock
);

  typedef enum logic [1:0] {AFE_IDLE, AFE_INSTR, AFE_DATA, AFE_DONE} afe_state_t;

  // Synchronised pins: clk, select, data
  // Select enters inverted so cleared flops read as deselected after reset
  logic [2:0] pins_s;
  afe_sync #(.WIDTH(3)) u_sync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in ({serial_clk, ~serial_select_n, serial_data_i}),
    .sync_out (pins_s)
  );
  wire sclk_s = pins_s[2];
  wire sel_n_s = ~pins_s[1];
  wire sdi_s = pins_s[0];

  afe_state_t         state_r, state_nxt;
  logic               sclk_d_r;
  logic [2:0]         bit_cnt_r;
  logic [7:0]         shift_r;
  afe_pkg::afe_instr_t instr_r;
  logic [1:0]         bytes_left_r;
  logic [4:0]         addr_r;
  logic [7:0]         tx_r;
  logic               sdo_r;
  logic               drive_r;
  logic [3:0]         srst_cnt_r;
  logic               soft_rst_r;
  logic [7:0]         rd_data;
  logic [7:0]         r0, r1, r3, r4, r5;
  afe_pkg::afe_ctrl_t ctrl_nxt;

  // Edge detection on synchronised serial clock
  wire rise = sclk_s & ~sclk_d_r;
  wire fall = ~sclk_s & sclk_d_r;
  wire lsb_first = r0[afe_pkg::BIT_LSB_FIRST];
  wire four_wire = r0[afe_pkg::BIT_FOUR_WIRE];
  wire active = ~sel_n_s & ~soft_rst_r;
  wire [7:0] shift_in = lsb_first ? {sdi_s, shift_r[7:1]} : {shift_r[6:0], sdi_s};
  wire byte_done = active & rise & (bit_cnt_r == afe_pkg::BIT_LAST);
  wire afe_pkg::afe_instr_t instr_nxt = afe_pkg::afe_instr_t'(shift_in);
  wire [4:0] addr_step = lsb_first ? addr_r + 5'h01 : addr_r - 5'h01;
  wire do_write = byte_done & (state_r == AFE_DATA) & ~instr_r.rd;
  wire soft_req = do_write & (addr_r == afe_pkg::REG_PORT_CFG) & shift_in[afe_pkg::BIT_SOFT_RST];
  wire [4:0] rd_addr = (state_r == AFE_INSTR) ? instr_nxt.addr : addr_step;
  wire load_tx = byte_done & ((state_r == AFE_INSTR) ? instr_nxt.rd : (instr_r.rd & bytes_left_r != 2'h0));

  afe_regfile #(.DIE_VERSION(DIE_VERSION)) u_regs (
    .clock    (clock),
    .nrst     (nrst),
    .soft_rst (soft_rst_r),
    .wr_en    (do_write),
    .wr_addr  (addr_r),
    .wr_data  (shift_in),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data),
    .r0       (r0),
    .r1       (r1),
    .r3       (r3),
    .r4       (r4),
    .r5       (r5)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      AFE_IDLE:  if (active) state_nxt = AFE_INSTR;
      AFE_INSTR: if (byte_done) state_nxt = AFE_DATA;
      AFE_DATA:  if (byte_done && bytes_left_r == 2'h0) state_nxt = AFE_DONE;
      AFE_DONE:  state_nxt = AFE_DONE;
      default:   state_nxt = AFE_IDLE;
    endcase
    if (!active) state_nxt = AFE_IDLE;
  end

  // serial engine, held off during resets
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_r      <= AFE_IDLE;
      sclk_d_r     <= 1'b0;
      bit_cnt_r    <= 3'h0;
      shift_r      <= 8'h00;
      instr_r      <= '0;
      bytes_left_r <= 2'h0;
      addr_r       <= 5'h00;
    end else begin
      state_r  <= state_nxt;
      sclk_d_r <= sclk_s;
      if (!active || state_r == AFE_IDLE) begin
        bit_cnt_r <= 3'h0;
      end else if (rise) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        shift_r   <= shift_in;
      end
      if (byte_done && state_r == AFE_INSTR) begin
        instr_r      <= instr_nxt;
        bytes_left_r <= instr_nxt.count;
        addr_r       <= instr_nxt.addr;
      end else if (byte_done && state_r == AFE_DATA) begin
        bytes_left_r <= bytes_left_r - 2'h1;
        addr_r       <= addr_step;
      end
    end
  end

  // read data shifted out on falling edges
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tx_r    <= 8'h00;
      sdo_r   <= 1'b0;
      drive_r <= 1'b0;
    end else begin
      if (load_tx) begin
        tx_r    <= rd_data;
        drive_r <= 1'b1;
      end else if (active && fall && drive_r) begin
        sdo_r <= lsb_first ? tx_r[0] : tx_r[7];
        tx_r  <= lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
      end
      if (!active || state_r == AFE_DONE) drive_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      srst_cnt_r <= 4'h0;
      soft_rst_r <= 1'b0;
    end else if (soft_req) begin
      srst_cnt_r <= afe_pkg::SOFT_RST_CYCLES;
      soft_rst_r <= 1'b1;
    end else if (srst_cnt_r != 4'h0) begin
      srst_cnt_r <= srst_cnt_r - 4'h1;
      soft_rst_r <= (srst_cnt_r != 4'h1);
    end
  end

  // Control decode toward the analog blocks
  always_comb begin
    ctrl_nxt = '0;
    ctrl_nxt.pd_rx_filter     = r1[afe_pkg::BIT_PD_FILT] | r4[afe_pkg::BIT_LPF_BYP];
    ctrl_nxt.bypass_rx_filter = r1[afe_pkg::BIT_PD_FILT] | r4[afe_pkg::BIT_LPF_BYP];
    ctrl_nxt.pd_adc_sgain     = r1[afe_pkg::BIT_PD_ADC];
    ctrl_nxt.pd_adc_ref       = r1[afe_pkg::BIT_PD_REF];
    ctrl_nxt.pd_interp        = r1[afe_pkg::BIT_PD_INTERP];
    ctrl_nxt.pd_dac           = r1[afe_pkg::BIT_PD_DAC];
    ctrl_nxt.pd_tx_pll        = r1[afe_pkg::BIT_PD_PLL];
    ctrl_nxt.clk_a_hiz        = r1[afe_pkg::BIT_PD_PLL];
    ctrl_nxt.pll_factor       = 4'h1 << r3[1:0];
    ctrl_nxt.adc_clk_div2     = r3[afe_pkg::BIT_ADC_DIV2];
    ctrl_nxt.one_pole_en      = r4[afe_pkg::BIT_ONE_POLE] & r4[afe_pkg::BIT_LPF_BYP];
    ctrl_nxt.tune_target      = r5;
    ctrl_nxt.wide_cutoff      = r4[afe_pkg::BIT_WIDE_LPF];
  end

  // Registered outputs; four-line pin selection
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl                 <= '0;
      pll_relock           <= 1'b0;
      serial_data_o        <= 1'b0;
      serial_data_oe_n     <= 1'b1;
      boost_or_serial_out  <= 1'b0;
      boost_or_serial_oe_n <= 1'b0;
    end else begin
      ctrl                 <= ctrl_nxt;
      pll_relock           <= soft_rst_r;
      serial_data_o        <= sdo_r;
      serial_data_oe_n     <= ~(drive_r & ~four_wire & active);
      boost_or_serial_out  <= (four_wire && drive_r && active) ? sdo_r : rx_boost_level;
      boost_or_serial_oe_n <= 1'b0;
    end
  end

  // pulse held for its full length
  sequence s_srst_hold;
    soft_rst_r [*8];
  endsequence

  // soft reset pulse drops after eight cycles
  a_soft_rst_len: assert property (@(posedge clock) disable iff (!nrst)
    $rose(soft_rst_r) |-> s_srst_hold ##1 !soft_rst_r)
    else $error("soft reset length wrong");
  a_relock_pulse: assert property (@(posedge clock) disable iff (!nrst)
    soft_rst_r |=> pll_relock)
    else $error("relock not raised during soft reset");
  // register 0 bit 5 reads zero after soft reset
  a_bit5_clear: assert property (@(posedge clock) disable iff (!nrst)
    $fell(soft_rst_r) |-> !r0[afe_pkg::BIT_SOFT_RST])
    else $error("soft reset bit not cleared");
  a_sel_ignore: assert property (@(posedge clock) disable iff (!nrst)
    sel_n_s |=> state_r == AFE_IDLE && !drive_r)
    else $error("activity while deselected");
  a_bit_count: assert property (@(posedge clock) disable iff (!nrst)
    (active && rise && state_r != AFE_IDLE) |=> bit_cnt_r == 3'($past(bit_cnt_r) + 3'h1))
    else $error("bit count step wrong");
  // address step direction, taken from the order in force at the byte
  a_addr_step: assert property (@(posedge clock) disable iff (!nrst)
    (byte_done && state_r == AFE_DATA) |=>
      addr_r == ($past(lsb_first) ? $past(addr_r) + 5'h01 : $past(addr_r) - 5'h01))
    else $error("address step wrong");
  a_pll_factor: assert property (@(posedge clock) disable iff (!nrst)
    r3[1:0] == 2'h3 |=> ctrl.pll_factor == 4'h8)
    else $error("multiplier factor wrong");
  a_adc_div: assert property (@(posedge clock) disable iff (!nrst)
    r3[afe_pkg::BIT_ADC_DIV2] |=> ctrl.adc_clk_div2)
    else $error("adc clock not halved");
  a_adc_down: assert property (@(posedge clock) disable iff (!nrst)
    r1[afe_pkg::BIT_PD_ADC] |=> ctrl.pd_adc_sgain)
    else $error("adc not powered down");
  a_clk_hiz: assert property (@(posedge clock) disable iff (!nrst)
    r1[afe_pkg::BIT_PD_PLL] |=> ctrl.clk_a_hiz)
    else $error("aux clock not floated");
  a_lpf_bypass: assert property (@(posedge clock) disable iff (!nrst)
    r4[afe_pkg::BIT_LPF_BYP] |=> ctrl.pd_rx_filter && ctrl.bypass_rx_filter)
    else $error("bypass not powered down");
  a_one_pole: assert property (@(posedge clock) disable iff (!nrst)
    !r4[afe_pkg::BIT_LPF_BYP] |=> !ctrl.one_pole_en)
    else $error("single pole on without bypass");
  // three-wire data pin released in four-line mode
  a_four_wire: assert property (@(posedge clock) disable iff (!nrst)
    four_wire |=> serial_data_oe_n)
    else $error("data pin driven in four-line mode");

endmodule // afe_ctrl_bank

// ==== sim/afe_host_model.sv ====
`timescale 1ns/1ns
// Host controller on the serial control port
module afe_host_model (
  // Clock
  input  wire logic clock,
  // Serial pins
  output logic      serial_clk,
  output logic      serial_select_n,
  output logic      serial_data_i,
  input  wire logic serial_data_o,
  input  wire logic serial_data_oe_n,
  input  wire logic boost_or_serial_out
);
  localparam int HALF = 8;  // Serial half period in clocks
  logic hbit;
  logic hdrv;

  // Data wire: device when enabled, else host bit, else inverse of last host bit
  assign serial_data_i = !serial_data_oe_n ? serial_data_o : (hdrv ? hbit : ~hbit);

  // Idle: select high, serial clock parked low
  initial begin
    serial_clk = 1'b0;
    serial_select_n = 1'b1;
    hbit = 1'b0;
    hdrv = 1'b1;
  end

  // Move to just after a clock edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // data held across the rise, read line taken at the rise
  task automatic bit_cycle(input logic b, input logic drv, input logic four, output logic got);
    if (drv)
      hbit = b;
    hdrv = drv;
    wait_clk(HALF);
    got = four ? boost_or_serial_out : serial_data_i;
    serial_clk = 1'b1;
    wait_clk(HALF);
    serial_clk = 1'b0;
  endtask

  // framed transfer of an instruction and n data bytes
  task automatic xfer(input logic rd, input int n, input logic [4:0] addr, input logic lsb, input logic four,
                      input logic [31:0] wdata, output logic [31:0] rdata, output logic oe_bad);
    logic [7:0] ins;
    logic [7:0] b;
    logic       got;
    int         k;
    int         i;
    ins = {rd, 2'(n - 1), addr};
    rdata = '0;
    oe_bad = 1'b0;
    wait_clk(1);
    serial_select_n = 1'b0;
    wait_clk(4);
    for (i = 0; i < 8; i++)
      bit_cycle(ins[lsb ? i : 7 - i], 1'b1, four, got);
    for (k = 0; k < n; k++) begin
      b = wdata[8*k +: 8];
      for (i = 0; i < 8; i++) begin
        bit_cycle(b[lsb ? i : 7 - i], !rd || four, four, got);
        rdata[8*k + (lsb ? i : 7 - i)] = got;
        if (four && !serial_data_oe_n)
          oe_bad = 1'b1;
      end
    end
    wait_clk(4);
    serial_select_n = 1'b1;
    hdrv = 1'b1;
    wait_clk(8);
  endtask

  // Stray serial clocks with select left high
  task automatic stray(input logic [15:0] w);
    logic got;
    int   i;
    for (i = 15; i >= 0; i--)
      bit_cycle(w[i], 1'b1, 1'b0, got);
  endtask
endmodule  // afe_host_model

// ==== sim/afe_control_register_bank_tb.sv ====
`timescale 1ns/1ns
// Self-checking bench for the serial control register bank
module afe_control_register_bank_tb;
  localparam logic [7:0]  DIE_VER = 8'h5a;  // Arbitrary value
  localparam int          LIMIT   = 60000;
  localparam logic [71:0] DFLT    = 72'h00_10_00_80_01_01_00_00_00;
  localparam logic [71:0] MASK    = 72'hfb_f3_bf_ff_bf_43_ff_3f_00;
  logic               clock;
  logic               nrst;
  logic               serial_clk;
  logic               serial_select_n;
  logic               serial_data_i;
  logic               serial_data_o;
  logic               serial_data_oe_n;
  logic               boost_or_serial_out;
  logic               boost_or_serial_oe_n;
  logic               rx_boost_level;
  afe_pkg::afe_ctrl_t ctrl;
  logic               pll_relock;
  logic               lsb_m;
  logic               four_m;
  logic               relock_seen;
  logic               oe_bad;
  logic [31:0]        rdat;
  int                 n_errors;
  int                 compares;
  int                 cycles;

  // Clock at 20 MHz
  initial clock = 1'b0;
  always #25 clock = ~clock;

  afe_ctrl_bank #(.DIE_VERSION(DIE_VER)) dut_u (
    .clock(clock), .nrst(nrst), .serial_clk(serial_clk), .serial_select_n(serial_select_n),
    .serial_data_i(serial_data_i), .serial_data_o(serial_data_o), .serial_data_oe_n(serial_data_oe_n),
    .boost_or_serial_out(boost_or_serial_out), .boost_or_serial_oe_n(boost_or_serial_oe_n),
    .rx_boost_level(rx_boost_level), .ctrl(ctrl), .pll_relock(pll_relock));

  afe_host_model host_u (
    .clock(clock), .serial_clk(serial_clk), .serial_select_n(serial_select_n), .serial_data_i(serial_data_i),
    .serial_data_o(serial_data_o), .serial_data_oe_n(serial_data_oe_n),
    .boost_or_serial_out(boost_or_serial_out));

  // Verdict and end of run
  task automatic test_done;
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard and relock pulse catcher
  always @(posedge clock) begin
    cycles++;
    if (pll_relock === 1'b1)
      relock_seen = 1'b1;
    if (cycles == LIMIT) begin
      n_errors++;
      test_done;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host_u.xfer(1'b0, 1, a, lsb_m, four_m, {24'h0, d}, rdat, oe_bad);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    host_u.xfer(1'b1, 1, a, lsb_m, four_m, 32'h0, rdat, oe_bad);
    check({24'h0, rdat[7:0]}, {24'h0, exp}, "register read");
  endtask

  task automatic hw_reset;
    @(posedge clock);
    #1 nrst = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check({31'h0, serial_data_oe_n}, 32'h1, "data pin released in reset");
    nrst = 1'b1;
    repeat (6) @(posedge clock);
    #1;
  endtask

  task automatic t_defaults;
    int i;
    for (i = 0; i < 9; i++)
      rd_chk(5'(i), DFLT[8*i +: 8]);
    rd_chk(5'h0f, DIE_VER);
    check({28'h0, ctrl.pll_factor}, 32'h2, "reset multiplier");
    check({30'h0, ctrl.bypass_rx_filter, ctrl.pd_rx_filter}, 32'h3, "reset filter bypass");
    check({24'h0, ctrl.tune_target}, 32'h80, "reset tuning target");
  endtask

  task automatic t_masks;
    int i;
    for (i = 1; i < 9; i++) begin
      wr(5'(i), 8'hff);
      rd_chk(5'(i), MASK[8*i +: 8]);
    end
    wr(5'h0f, 8'h00);
    rd_chk(5'h0f, DIE_VER);
    rd_chk(5'h0a, 8'h00);
    hw_reset;
    rd_chk(5'h01, 8'h00);
  endtask

  task automatic t_clock_src;
    int c;
    for (c = 0; c < 4; c++) begin
      wr(5'h03, {1'b0, c[0], 4'h0, c[1:0]});
      check({28'h0, ctrl.pll_factor}, 32'(1 << c), "multiplier factor");
      check({31'h0, ctrl.adc_clk_div2}, {31'h0, c[0]}, "adc clock halved");
    end
  endtask

  task automatic t_power;
    int b;
    wr(5'h04, 8'h00);
    for (b = 0; b < 6; b++) begin
      wr(5'h01, 8'(1 << b));
      check({26'h0, ctrl.pd_tx_pll, ctrl.pd_dac, ctrl.pd_interp, ctrl.pd_adc_ref, ctrl.pd_adc_sgain,
             ctrl.pd_rx_filter}, 32'(1 << b), "power-down bit");
      check({30'h0, ctrl.clk_a_hiz, ctrl.bypass_rx_filter}, {30'h0, b == 5, b == 0}, "hiz and bypass");
    end
    wr(5'h04, 8'h03);
    check({29'h0, ctrl.one_pole_en, ctrl.bypass_rx_filter, ctrl.pd_rx_filter}, 32'h7, "one pole bypass");
    wr(5'h04, 8'h04);
    check({29'h0, ctrl.wide_cutoff, ctrl.one_pole_en, ctrl.bypass_rx_filter}, 32'h4, "wide cutoff");
  endtask

  task automatic t_multi_msb;
    host_u.xfer(1'b0, 3, 5'h05, 1'b0, 1'b0, 32'h00_42_02_21, rdat, oe_bad);
    check({24'h0, ctrl.tune_target}, 32'h21, "tuning target");
    host_u.xfer(1'b1, 4, 5'h06, 1'b0, 1'b0, 32'h0, rdat, oe_bad);
    check(rdat, 32'h42_02_21_00, "msb first multibyte read");
  endtask

  task automatic t_lsb;
    wr(5'h00, 8'h40);
    lsb_m = 1'b1;
    rd_chk(5'h00, 8'h40);
    host_u.xfer(1'b0, 2, 5'h05, 1'b1, 1'b0, 32'h0000_7733, rdat, oe_bad);
    host_u.xfer(1'b1, 2, 5'h05, 1'b1, 1'b0, 32'h0, rdat, oe_bad);
    check(rdat, 32'h0000_3733, "lsb first multibyte read");
    wr(5'h00, 8'h00);
    lsb_m = 1'b0;
    rd_chk(5'h00, 8'h00);
  endtask

  task automatic t_four;
    wr(5'h00, 8'h80);
    four_m = 1'b1;
    rx_boost_level = 1'b1;
    repeat (6) @(posedge clock);
    #1;
    check({30'h0, boost_or_serial_out, boost_or_serial_oe_n}, 32'h2, "boost level copied");
    rd_chk(5'h05, 8'h33);
    check({31'h0, oe_bad}, 32'h0, "data pin input only");
    rx_boost_level = 1'b0;
    wr(5'h00, 8'h00);
    four_m = 1'b0;
    check({31'h0, boost_or_serial_out}, 32'h0, "boost level copied");
  endtask

  task automatic t_soft;
    wr(5'h05, 8'h5c);
    relock_seen = 1'b0;
    wr(5'h00, 8'h60);
    check({31'h0, relock_seen}, 32'h1, "relock pulse");
    lsb_m = 1'b1;
    rd_chk(5'h00, 8'h40);
    rd_chk(5'h05, 8'h80);
    wr(5'h00, 8'h00);
    lsb_m = 1'b0;
  endtask

  task automatic t_ignore;
    host_u.stray(16'h0500);
    rd_chk(5'h05, 8'h80);
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    rx_boost_level = 1'b0;
    lsb_m = 1'b0;
    four_m = 1'b0;
    relock_seen = 1'b0;
    n_errors = 0;
    compares = 0;
    cycles = 0;
    hw_reset;
    t_defaults;
    t_masks;
    t_clock_src;
    t_power;
    t_multi_msb;
    t_lsb;
    t_four;
    t_soft;
    t_ignore;
    test_done;
  end
endmodule  // afe_control_register_bank_tb
